// ---- hw/swmsc_pkg.sv ----
// Shared constants, types and decode functions for the switch monitor setup control block.
// Assumes a single 100 MHz clock and a setup word written whole by a same-clock serial front end.
`default_nettype none

package swmsc_pkg;

    // Width of the setup word.
    localparam int unsigned CFG_W = 24;

    // Field positions inside the setup word.
    localparam int unsigned BIT_SOFT_RESET  = 0;
    localparam int unsigned PERIOD_LSB      = 1;
    localparam int unsigned SAMPLE_ON_LSB   = 5;
    localparam int unsigned BIT_CRC_TRIGGER = 9;
    localparam int unsigned BIT_POLL_SELECT = 10;
    localparam int unsigned BIT_RUN         = 11;
    localparam int unsigned BIT_INT_SCHEME  = 12;
    localparam int unsigned BIT_TW_CUTBACK  = 13;

    // Reset value of the setup word.
    localparam logic [23:0] CFG_RESET = 24'h000000;

    // Bits that may change while running: run, checksum trigger and soft reset.
    localparam logic [23:0] RUN_WRITABLE_MASK = 24'h000A01;

    // Checksum engine polynomial and seed.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'hFF;
    localparam logic [4:0] CRC_LAST = 5'h17;

    // Wetting current codes: 0, 1, 2, 5, 10 and 15 mA.
    localparam logic [2:0] WET_OFF  = 3'h0;
    localparam logic [2:0] WET_2MA  = 3'h2;
    localparam logic [2:0] WET_10MA = 3'h4;
    localparam logic [2:0] WET_15MA = 3'h5;

    // Timing: the clock period and the low time of a dynamic interrupt pulse.
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned INT_PULSE_NS   = 5000;
    localparam logic [9:0]  INT_PULSE_CYC  = 10'(INT_PULSE_NS / CLK_PERIOD_NS);

    // Step of the low active-time codes, in microseconds.
    localparam logic [11:0] SAMPLE_STEP_US = 12'h040;

    // States of the checksum engine.
    typedef enum logic [0:0] {
        SWMSC_CRC_IDLE = 1'b0,
        SWMSC_CRC_BUSY = 1'b1
    } swmsc_crc_state_e;

    // Turns the four-bit active-time code into microseconds.
    function automatic logic [11:0] swmsc_sample_on_us(input logic [3:0] code);
        logic [11:0] us;
        us = 12'h200;
        if (code < 4'h8) begin
            us = 12'({8'h00, code} + 12'h001) * SAMPLE_STEP_US;
        end else begin
            unique case (code)
                4'h8:    us = 12'h280;
                4'h9:    us = 12'h300;
                4'hA:    us = 12'h380;
                4'hB:    us = 12'h400;
                4'hC:    us = 12'h800;
                default: us = 12'h200;
            endcase
        end
        return us;
    endfunction

    // Turns the four-bit polling period code into milliseconds.
    function automatic logic [12:0] swmsc_period_ms(input logic [3:0] code);
        logic [12:0] ms;
        ms = 13'h0008;
        unique case (code)
            4'h0:    ms = 13'h0002;
            4'h1:    ms = 13'h0004;
            4'h2:    ms = 13'h0008;
            4'h3:    ms = 13'h0010;
            4'h4:    ms = 13'h0020;
            4'h5:    ms = 13'h0030;
            4'h6:    ms = 13'h0040;
            4'h7:    ms = 13'h0080;
            4'h8:    ms = 13'h0100;
            4'h9:    ms = 13'h0200;
            4'hA:    ms = 13'h0400;
            4'hB:    ms = 13'h0800;
            4'hC:    ms = 13'h1000;
            default: ms = 13'h0008;
        endcase
        return ms;
    endfunction

endpackage

`default_nettype wire

// ---- hw/swmsc_crc_if.sv ----
// Interface between the setup controller and its checksum engine.
// Assumes both ends run on the same clock.
`default_nettype none

interface swmsc_crc_if;
    logic        start;   // One-cycle request to start a checksum run.
    logic        abort;   // One-cycle request to drop a run in progress.
    logic [23:0] data;    // Configuration snapshot taken at start.
    logic        busy;    // High while a run is in progress.
    logic        done;    // One-cycle pulse when a run completes.
    logic [7:0]  result;  // Checksum of the last completed run.

    // Controller end.
    modport ctrl (output start, abort, data, input busy, done, result);
    // Engine end.
    modport eng (input start, abort, data, output busy, done, result);
endinterface

`default_nettype wire

// ---- hw/swmsc_crc.sv ----
// Serial checksum engine: one configuration bit per clock, 24 clocks per run.
// Assumes a start pulse with a stable snapshot and a reset already synchronised.
`default_nettype none

module swmsc_crc (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    swmsc_crc_if.eng         crc
);

    // All engine state in one record.
    typedef struct packed {
        swmsc_pkg::swmsc_crc_state_e state;
        logic [23:0]                 shreg;
        logic [4:0]                  cnt;
        logic [7:0]                  crc;
        logic                        busy;
        logic                        done;
        logic [7:0]                  result;
    } swmsc_crc_s;

    swmsc_crc_s r_reg;  // Registered state.
    swmsc_crc_s r_next; // Next state.

    // Shifts one bit per cycle and reports the result after the last bit.
    always_comb begin
        logic       fb;
        logic [7:0] crc_new;
        fb      = r_reg.crc[7] ^ r_reg.shreg[23];
        crc_new = {r_reg.crc[6:0], 1'b0} ^ (fb ? swmsc_pkg::CRC_POLY : 8'h00);
        r_next      = r_reg;
        r_next.done = 1'b0;
        unique case (r_reg.state)
            swmsc_pkg::SWMSC_CRC_IDLE: begin
                // A start loads the snapshot and seeds the checksum.
                if (crc.start) begin
                    r_next.state = swmsc_pkg::SWMSC_CRC_BUSY;
                    r_next.shreg = crc.data;
                    r_next.crc   = swmsc_pkg::CRC_INIT;
                    r_next.cnt   = 5'h00;
                    r_next.busy  = 1'b1;
                end
            end
            swmsc_pkg::SWMSC_CRC_BUSY: begin
                // One configuration bit enters per cycle, MSB first.
                r_next.crc   = crc_new;
                r_next.shreg = {r_reg.shreg[22:0], 1'b0};
                r_next.cnt   = r_reg.cnt + 5'h01;
                if (r_reg.cnt == swmsc_pkg::CRC_LAST) begin
                    r_next.state  = swmsc_pkg::SWMSC_CRC_IDLE;
                    r_next.busy   = 1'b0;
                    r_next.done   = 1'b1;
                    r_next.result = crc_new;
                end
            end
        endcase
        // An abort from a soft reset drops any run without a done pulse.
        if (crc.abort) begin
            r_next.state = swmsc_pkg::SWMSC_CRC_IDLE;
            r_next.busy  = 1'b0;
            r_next.done  = 1'b0;
        end
    end

    // Registers the engine state.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_reg <= '{state: swmsc_pkg::SWMSC_CRC_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign crc.busy   = r_reg.busy;
    assign crc.done   = r_reg.done;
    assign crc.result = r_reg.result;

endmodule

`default_nettype wire

// ---- hw/swmsc_top.sv ----
// Setup word controller for a switch monitor: run control, mode, checksum, interrupt and soft reset.
// Assumes the serial front end delivers whole setup words on i_clk; the thermal warning is asynchronous.
`default_nettype none

// Overview of operation
// - Thermal warning cuts 10/15 mA sourcing to 2 mA.
// - Interrupt scheme bit: 0 static, 1 dynamic.
// - Run bit 1 starts operation, 0 idles.
// - While running only run, checksum, reset writable.
// - Poll select: 0 continuous, 1 polling mode.
// - Checksum trigger computes CRC over configuration bits.
// - Checksum completion sets flag, pulls interrupt low.
// - Checksum trigger bit clears itself when done.
// - Active-time code maps to microsecond durations.
// - Period code maps to millisecond durations.
// - Writing 1 to reset bit resets device.
// - All fields come out of reset zero.
module swmsc_top (
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_setup_wr,
    input  wire logic [23:0] i_setup_wdata,
    input  wire logic        i_flag_clear,
    input  wire logic        i_thermal_warning_event,
    input  wire logic        i_current_sourcing_input_type,
    input  wire logic [2:0]  i_wet_setting,
    output logic [23:0]      o_setup_rdata,
    output logic             o_run,
    output logic             o_polling_mode,
    output logic [11:0]      o_sample_on_duration_us,
    output logic [12:0]      o_poll_period_ms,
    output logic [2:0]       o_wet_code_eff,
    output logic             o_wet_reduced,
    output logic             o_checksum_done_flag,
    output logic [7:0]       o_crc_result,
    output logic             o_int_n,
    output logic             o_soft_reset_pulse
);

    // All controller state except the reset synchroniser in one record.
    typedef struct packed {
        logic [23:0] cfg;        // The setup word.
        logic        crc_start;  // Start pulse towards the engine.
        logic        crc_abort;  // Abort pulse towards the engine.
        logic        flag;       // Sticky checksum-done flag.
        logic [9:0]  pulse_cnt;  // Remaining low time of a dynamic pulse.
        logic        int_n;      // Interrupt pin, active low.
        logic        tw_s1;      // Thermal warning, first sync stage.
        logic        tw_s2;      // Thermal warning, second sync stage.
        logic [11:0] on_us;      // Decoded active time.
        logic [12:0] period_ms;  // Decoded polling period.
        logic [2:0]  wet_eff;    // Wetting current code in force.
        logic        wet_red;    // High while the thermal cutback applies.
        logic [7:0]  crc_res;    // Last checksum.
        logic        soft_rst;   // Soft reset pulse.
    } swmsc_top_s;

    logic        rst_s1;  // Reset release, first stage.
    logic        rst_n;   // Reset release, synchronised copy.
    swmsc_top_s  r_reg;   // Registered state.
    swmsc_top_s  r_next;  // Next state.
    swmsc_crc_if crc_bus ();

    // Releases the reset through two flip-flops.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Checksum engine.
    swmsc_crc u_crc (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .crc     (crc_bus.eng)
    );

    assign crc_bus.start = r_reg.crc_start;
    assign crc_bus.abort = r_reg.crc_abort;
    assign crc_bus.data  = r_reg.cfg;

    // Computes the next state from writes, engine events and the warning input.
    always_comb begin
        logic [23:0] wmask;
        logic        big_wet;
        wmask   = 24'hFFFFFF;
        big_wet = (i_wet_setting == swmsc_pkg::WET_10MA) || (i_wet_setting == swmsc_pkg::WET_15MA);
        r_next           = r_reg;
        r_next.crc_start = 1'b0;
        r_next.crc_abort = 1'b0;
        r_next.soft_rst  = 1'b0;
        r_next.tw_s1     = i_thermal_warning_event;
        r_next.tw_s2     = r_reg.tw_s1;

        // A write updates the word; while running only the safe bits follow it.
        if (i_setup_wr) begin
            if (r_reg.cfg[swmsc_pkg::BIT_RUN]) begin
                wmask = swmsc_pkg::RUN_WRITABLE_MASK;
            end
            r_next.cfg = (r_reg.cfg & ~wmask) | (i_setup_wdata & wmask);
            // The trigger stays set while a run is busy, so a second 1 starts nothing.
            if (r_reg.cfg[swmsc_pkg::BIT_CRC_TRIGGER]) begin
                r_next.cfg[swmsc_pkg::BIT_CRC_TRIGGER] = 1'b1;
            end else if (i_setup_wdata[swmsc_pkg::BIT_CRC_TRIGGER]) begin
                r_next.crc_start = 1'b1;
            end
        end

        // Completion clears the trigger and raises the flag; the set beats a clear.
        if (crc_bus.done) begin
            r_next.cfg[swmsc_pkg::BIT_CRC_TRIGGER] = 1'b0;
            r_next.crc_res = crc_bus.result;
            r_next.flag    = 1'b1;
        end else if (i_flag_clear) begin
            r_next.flag = 1'b0;
        end

        // A soft reset returns every field and flag to zero and drops the checksum run.
        if (i_setup_wr && i_setup_wdata[swmsc_pkg::BIT_SOFT_RESET]) begin
            r_next.cfg       = swmsc_pkg::CFG_RESET;
            r_next.flag      = 1'b0;
            r_next.crc_res   = 8'h00;
            r_next.crc_start = 1'b0;
            r_next.crc_abort = 1'b1;
            r_next.soft_rst  = 1'b1;
        end

        // Static holds the pin low with the flag; dynamic gives one fixed low pulse.
        if (r_next.flag && !r_reg.flag) begin
            r_next.pulse_cnt = swmsc_pkg::INT_PULSE_CYC;
        end else if (r_reg.pulse_cnt != 10'h000) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 10'h001;
        end
        if (r_next.cfg[swmsc_pkg::BIT_INT_SCHEME]) begin
            r_next.int_n = (r_next.pulse_cnt == 10'h000);
        end else begin
            r_next.int_n = !r_next.flag;
        end

        // Decoded timings follow the word.
        r_next.on_us     = swmsc_pkg::swmsc_sample_on_us(r_next.cfg[8:5]);
        r_next.period_ms = swmsc_pkg::swmsc_period_ms(r_next.cfg[4:1]);

        // Wetting current: none while stopped, cut to 2 mA on a warning unless disabled.
        r_next.wet_red = 1'b0;
        if (!r_next.cfg[swmsc_pkg::BIT_RUN]) begin
            r_next.wet_eff = swmsc_pkg::WET_OFF;
        end else if (r_reg.tw_s2 && i_current_sourcing_input_type && big_wet
                     && !r_next.cfg[swmsc_pkg::BIT_TW_CUTBACK]) begin
            r_next.wet_eff = swmsc_pkg::WET_2MA;
            r_next.wet_red = 1'b1;
        end else begin
            r_next.wet_eff = i_wet_setting;
        end
    end

    // Registers the controller state; every field starts at zero except int_n high and the decoded timings of code 0.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg           <= '0;
            r_reg.int_n     <= 1'b1;
            r_reg.on_us     <= 12'h040;
            r_reg.period_ms <= 13'h0002;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_setup_rdata           = r_reg.cfg;
    assign o_run                   = r_reg.cfg[swmsc_pkg::BIT_RUN];
    assign o_polling_mode          = r_reg.cfg[swmsc_pkg::BIT_POLL_SELECT];
    assign o_sample_on_duration_us = r_reg.on_us;
    assign o_poll_period_ms        = r_reg.period_ms;
    assign o_wet_code_eff          = r_reg.wet_eff;
    assign o_wet_reduced           = r_reg.wet_red;
    assign o_checksum_done_flag    = r_reg.flag;
    assign o_crc_result            = r_reg.crc_res;
    assign o_int_n                 = r_reg.int_n;
    assign o_soft_reset_pulse      = r_reg.soft_rst;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    // A checksum request followed one cycle later by the engine reporting busy.
    sequence s_crc_launch;
        r_reg.crc_start ##1 crc_bus.busy;
    endsequence

    AST_RUN_PROTECTS_FIELDS:
    assert property (i_setup_wr && o_run && !i_setup_wdata[0]
                     |=> (o_setup_rdata & ~swmsc_pkg::RUN_WRITABLE_MASK)
                         == ($past(o_setup_rdata) & ~swmsc_pkg::RUN_WRITABLE_MASK))
        else $error("Protected field changed while running.");
    AST_RUN_START:
    assert property (i_setup_wr && i_setup_wdata[11] && !i_setup_wdata[0] |=> o_run)
        else $error("Run bit write did not start operation.");
    AST_STOP_IDLES:
    assert property (!o_run |-> o_wet_code_eff == 3'h0)
        else $error("Wetting current active while stopped.");
    AST_CRC_TIMING:
    assert property (s_crc_launch |-> ##24 crc_bus.done ##1 (o_checksum_done_flag && !o_setup_rdata[9]))
        else $error("Checksum did not finish in 24 cycles.");
    AST_CRC_SELF_CLEAR:
    assert property (crc_bus.done && !(i_setup_wr && i_setup_wdata[0]) |=> !o_setup_rdata[9] && o_checksum_done_flag)
        else $error("Checksum trigger did not clear or flag not set.");
    AST_INT_STATIC:
    assert property (o_checksum_done_flag && !o_setup_rdata[12] |-> !o_int_n)
        else $error("Static interrupt not low with flag set.");
    AST_INT_DYNAMIC:
    assert property ($fell(o_int_n) && o_setup_rdata[12] |-> !o_int_n [*8])
        else $error("Dynamic interrupt pulse too short.");
    AST_THERMAL_CUT:
    assert property (o_wet_reduced |-> o_wet_code_eff == 3'h2 && !o_setup_rdata[13] && o_run)
        else $error("Thermal cutback state inconsistent.");
    AST_SOFT_RESET:
    assert property (i_setup_wr && i_setup_wdata[0] |=> o_setup_rdata == 24'h000000 && !o_checksum_done_flag
                     && o_soft_reset_pulse)
        else $error("Soft reset did not clear the word.");
    AST_DECODE:
    assert property (o_sample_on_duration_us == swmsc_pkg::swmsc_sample_on_us(o_setup_rdata[8:5])
                     && o_poll_period_ms == swmsc_pkg::swmsc_period_ms(o_setup_rdata[4:1]))
        else $error("Timing decode does not match the word.");

endmodule

`default_nettype wire

// ---- testbench/swmsc_mcu_model.sv ----
// Behavioural model of the microcontroller that writes whole setup words.
// Assumes the same clock as the controller and writes issued one at a time.
`default_nettype none

module swmsc_mcu_model (
    input  wire logic        i_clk,
    output var  logic        o_wr,
    output var  logic [23:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_wr    = 1'b0;
        o_wdata = 24'h000000;
    end

    // Sends one word: strobe for one cycle, then the data lines show the inverse of the last word.
    // The caller stops the run before any change of setting other than the one guarded write it tests, and holds the setup still
    // while a checksum is in progress.
    task automatic send(input logic [23:0] w);
        @(posedge i_clk);
        #1;
        o_wr    = 1'b1;
        o_wdata = w;
        @(posedge i_clk);
        #1;
        o_wr    = 1'b0;
        o_wdata = ~w;
    endtask
endmodule

`default_nettype wire

// ---- testbench/test_switch_monitor_setup_control.sv ----
// Self-checking bench for the setup word controller: fields, run guard, checksum, cutback, soft reset.
// Assumes the design under hw/ and the controller model beside this file.
`default_nettype none

module test_switch_monitor_setup_control;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;                        // Core clock.
    logic        nrst;                       // Reset, active low.
    logic        flag_clr;                   // Checksum flag clear.
    logic        tw;                         // Thermal warning level.
    logic        src;                        // Input uses current sourcing.
    logic [2:0]  wet;                        // Requested wetting code.
    logic        wr;                         // Write strobe from the model.
    logic [23:0] wdata;                      // Write data from the model.
    logic [23:0] rdata;                      // Setup word readback.
    logic        run, poll, wred, flag, int_n, srst;
    logic [11:0] act_us;                     // Decoded active time.
    logic [12:0] per_ms;                     // Decoded period.
    logic [2:0]  wet_eff;                    // Wetting code in force.
    logic [7:0]  crc;                        // Checksum result.
    int          fails;                      // Mismatches seen.
    int          n_checks;                   // Comparisons made.
    int          n;                          // Cycle counter for waits.
    logic [11:0] act_tab [16] = '{12'h040, 12'h080, 12'h0C0, 12'h100, 12'h140, 12'h180, 12'h1C0, 12'h200,
                                  12'h280, 12'h300, 12'h380, 12'h400, 12'h800, 12'h200, 12'h200, 12'h200};
    logic [12:0] per_tab [16] = '{13'h0002, 13'h0004, 13'h0008, 13'h0010, 13'h0020, 13'h0030, 13'h0040,
                                  13'h0080, 13'h0100, 13'h0200, 13'h0400, 13'h0800, 13'h1000, 13'h0008,
                                  13'h0008, 13'h0008};

    swmsc_mcu_model mcu_u (
        .i_clk   (clk),
        .o_wr    (wr),
        .o_wdata (wdata)
    );

    swmsc_top dut_u (
        .i_clk                         (clk),
        .i_nrst                        (nrst),
        .i_setup_wr                    (wr),
        .i_setup_wdata                 (wdata),
        .i_flag_clear                  (flag_clr),
        .i_thermal_warning_event       (tw),
        .i_current_sourcing_input_type (src),
        .i_wet_setting                 (wet),
        .o_setup_rdata                 (rdata),
        .o_run                         (run),
        .o_polling_mode                (poll),
        .o_sample_on_duration_us       (act_us),
        .o_poll_period_ms              (per_ms),
        .o_wet_code_eff                (wet_eff),
        .o_wet_reduced                 (wred),
        .o_checksum_done_flag          (flag),
        .o_crc_result                  (crc),
        .o_int_n                       (int_n),
        .o_soft_reset_pulse            (srst)
    );

    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Waits a number of cycles, then 1 ns more past the last edge.
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Bench view of the checksum: polynomial 0x07, seed 0xFF, bit 23 first.
    function automatic logic [7:0] exp_crc(input logic [23:0] w);
        logic [7:0] c;
        logic       fb;
        c = 8'hFF;
        for (int i = 23; i >= 0; i--) begin
            fb = c[7] ^ w[i];
            c  = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // Starts a checksum on word w and waits for the flag, counting the cycles.
    task automatic run_crc(input logic [23:0] w);
        mcu_u.send(w);
        n = 0;
        while (flag !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        fails++;
        give_verdict();
    end

    // Main sequence of tests.
    initial begin
        fails = 0;
        n_checks = 0;
        nrst = 1'b0;
        flag_clr = 1'b0;
        tw = 1'b0;
        src = 1'b0;
        wet = 3'h0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        cyc(4);
        chk(rdata, 24'h000000, "reset word");
        chk({run, poll, int_n, flag}, 4'h2, "reset flags");
        chk(act_us, 12'h040, "reset active time");
        chk(per_ms, 13'h0002, "reset period");
        $display("Test reset values done");

        // Every active-time and period code, stopped, polling selected.
        for (int c = 0; c < 16; c++) begin
            mcu_u.send({15'h0002, c[3:0], c[3:0], 1'b0});
            chk(act_us, act_tab[c], "active time code");
            chk(per_ms, per_tab[c], "period code");
            chk(poll, 1'b1, "polling mode");
        end
        mcu_u.send(24'h000000);
        chk(poll, 1'b0, "continuous mode");
        $display("Test field decode done");

        // Run, then a refused change of mode while running, then cutback.
        src = 1'b1;
        wet = 3'h5;
        mcu_u.send(24'h000800);
        chk(run, 1'b1, "run set");
        chk(wet_eff, 3'h5, "wetting in force");
        mcu_u.send(24'h000C22);
        chk(rdata, 24'h000800, "guarded write");
        tw = 1'b1;
        cyc(4);
        chk({wred, wet_eff}, 4'hA, "thermal cutback");
        // The 10 mA setting is cut as well, 5 mA and sinking inputs are left alone.
        wet = 3'h4;
        cyc(1);
        chk({wred, wet_eff}, 4'hA, "cutback from 10 mA");
        wet = 3'h3;
        cyc(1);
        chk({wred, wet_eff}, 4'h3, "no cutback at 5 mA");
        wet = 3'h5;
        src = 1'b0;
        cyc(1);
        chk({wred, wet_eff}, 4'h5, "no cutback when sinking");
        src = 1'b1;
        mcu_u.send(24'h000000);
        chk({run, wet_eff}, 4'h0, "stopped idle");
        mcu_u.send(24'h002000);
        mcu_u.send(24'h002800);
        cyc(1);
        chk({wred, wet_eff}, 4'h5, "cutback disabled");
        tw = 1'b0;
        mcu_u.send(24'h000000);
        $display("Test run and cutback done");

        // Checksum with static interrupt, then cleared.
        run_crc(24'h00025A);
        chk(n, 26, "checksum latency");
        chk(crc, exp_crc(24'h00025A), "checksum value");
        chk(rdata, 24'h00005A, "trigger cleared");
        chk({flag, int_n}, 2'h2, "flag and pin low");
        flag_clr = 1'b1;
        cyc(1);
        flag_clr = 1'b0;
        cyc(1);
        chk({flag, int_n}, 2'h1, "flag cleared");
        // Checksum while running with dynamic interrupt pulse.
        mcu_u.send(24'h001000);
        mcu_u.send(24'h001800);
        run_crc(24'h001A00);
        chk(crc, exp_crc(24'h001A00), "running checksum");
        chk(int_n, 1'b0, "dynamic pulse low");
        cyc(495);
        chk(int_n, 1'b0, "dynamic pulse held");
        cyc(10);
        chk({flag, int_n}, 2'h3, "dynamic pulse ended");
        $display("Test checksum done");

        // Soft reset while running returns every field to zero.
        mcu_u.send(24'h001801);
        n = int'(srst);
        cyc(2);
        chk({n[1:0], srst}, 3'h2, "soft reset pulse");
        chk(rdata, 24'h000000, "word after soft reset");
        chk({run, flag, crc}, 10'h000, "state after soft reset");
        mcu_u.send(24'h000000);
        chk(rdata, 24'h000000, "zero write no effect");
        $display("Test soft reset done");
        give_verdict();
    end
endmodule

`default_nettype wire
